// ---- verilog/clock_gen_serial_config.v ----
// Write-only two-wire configuration receiver and output gating of the clock generator.
// Assumes the serial clock is far slower than clk_sys (250 MHz) and the source clocks
// come from the synthesiser, which slews to a new select code on its own loop.
`timescale 1ns/1ps
`include "clock_gen_serial_config_defines.vh"
module clock_gen_serial_config (
    input  wire       clk_sys,                  // System clock
    input  wire       rstn,                     // Async reset, active low
    input  wire       config_serial_clock_pin,  // Serial clock pin
    input  wire       config_serial_data_pin,   // Serial data pin level
    output wire       config_serial_data_out,   // Serial data drive value
    output wire       config_serial_data_oe_n,  // Serial data drive, low drives
    input  wire [3:0] strap_freq_select_inputs, // Strap select, sampled every clk_sys cycle
    input  wire       proc_clk_src,             // CPU clock from synthesiser
    input  wire       bus_clk_src,              // PCI clock from synthesiser
    input  wire       mem_clk_src,              // Buffered SDRAM input
    input  wire       usb_clk_src,              // 48 MHz source
    input  wire       superio_clk_src,          // 24 MHz source
    input  wire       crystal_clk_src,          // Crystal reference source
    output wire [3:0] freq_select_active,       // Code steering synthesiser
    output wire       freq_from_software,       // Software select in force
    output wire       spread_enable,            // Modulation on
    output wire       freq_update,              // Pulse on new select code
    output wire       clocks_oe_n,              // Three-state, low drives
    output wire       proc_clock_out_free,      // Free-running CPU clock
    output wire       proc_clock_out_one,       // CPU clock 1
    output wire       proc_clock_out_two,       // CPU clock 2
    output wire       proc_clock_out_three,     // CPU clock 3
    output wire       bus_clock_out_free,       // Free-running PCI clock
    output wire       bus_clock_out_one,        // PCI clock 1
    output wire       bus_clock_out_two,        // PCI clock 2
    output wire       bus_clock_out_three,      // PCI clock 3
    output wire       bus_clock_out_four,       // PCI clock 4
    output wire       bus_clock_out_five,       // PCI clock 5
    output wire       usb_reference_clock_out,  // 48 MHz output
    output wire       superio_clock_out,        // 24 MHz output
    output wire       memory_buffer_free,       // Free-running SDRAM buffer
    output wire [3:0] memory_buffer_group_low,  // SDRAM buffers 0-3
    output wire [3:0] memory_buffer_group_mid,  // SDRAM buffers 4-7
    output wire [3:0] memory_buffer_group_high, // SDRAM buffers 8-11
    output wire       crystal_copy_out_zero,    // Reference output 0
    output wire       crystal_copy_out_one      // Reference output 1
);

    // ------------------------------------------------------------------
    // Per-byte tables
    // ------------------------------------------------------------------
    function [7:0] byte_default;
        input [2:0] idx;
        begin
            if (idx == `BYTE_FREQ) begin
                byte_default = `DFLT_FREQ;
            end else if (idx == `BYTE_CPU) begin
                byte_default = `DFLT_CPU;
            end else if (idx == `BYTE_PCI) begin
                byte_default = `DFLT_PCI;
            end else if (idx == `BYTE_AUX) begin
                byte_default = `DFLT_AUX;
            end else if (idx == `BYTE_REF) begin
                byte_default = `DFLT_REF;
            end else begin
                byte_default = `DFLT_RSVD;
            end
        end
    endfunction

    // Reserved bits never reach storage, so a careless master cannot set them
    function [7:0] byte_mask;
        input [2:0] idx;
        begin
            if (idx == `BYTE_FREQ) begin
                byte_mask = `MASK_FREQ;
            end else if (idx == `BYTE_CPU) begin
                byte_mask = `MASK_CPU;
            end else if (idx == `BYTE_PCI) begin
                byte_mask = `MASK_PCI;
            end else if (idx == `BYTE_AUX) begin
                byte_mask = `MASK_AUX;
            end else if (idx == `BYTE_REF) begin
                byte_mask = `MASK_REF;
            end else begin
                byte_mask = `MASK_RSVD;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    wire [5:0] pins_s;
    wire       scl_s;
    wire       sda_s;
    wire [3:0] strap_s;

    serial_line_sampler u_sampler (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in ({strap_freq_select_inputs, config_serial_data_pin, config_serial_clock_pin}),
        .sync_out (pins_s)
    );

    assign scl_s   = pins_s[0];
    assign sda_s   = pins_s[1];
    assign strap_s = pins_s[5:2];

    reg scl_q;
    reg sda_q;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [3:0] byte_idx_q;
    reg [3:0] byte_idx_d;
    reg [2:0] bit_cnt_q;
    reg [2:0] bit_cnt_d;
    reg [7:0] shift_q;
    reg [7:0] shift_d;
    reg       matched_q;
    reg       matched_d;
    reg       ack_ok_q;
    reg       ack_ok_d;
    reg       ack_drive_q;
    reg       ack_drive_d;
    reg       byte_done_q;
    reg       byte_done_d;
    reg       commit_c;

    wire [3:0] data_pos = byte_idx_q - `FIRST_DATA_IDX;
    wire [7:0] rx_byte  = {shift_q[6:0], sda_s};
    wire       in_data  = (byte_idx_q >= `FIRST_DATA_IDX) && (byte_idx_q < `XFER_BYTES);

    always @* begin
        state_d     = state_q;
        byte_idx_d  = byte_idx_q;
        bit_cnt_d   = bit_cnt_q;
        shift_d     = shift_q;
        matched_d   = matched_q;
        ack_ok_d    = ack_ok_q;
        ack_drive_d = ack_drive_q;
        byte_done_d = byte_done_q;
        commit_c    = 1'b0;
        if (start_c) begin
            // A repeated start resynchronises byte positions to the address
            state_d     = `ST_BITS;
            byte_idx_d  = 4'h0;
            bit_cnt_d   = 3'h0;
            matched_d   = 1'b0;
            ack_ok_d    = 1'b0;
            byte_done_d = 1'b0;
            ack_drive_d = 1'b0;
        end else if (stop_c) begin
            state_d     = `ST_IDLE;
            ack_drive_d = 1'b0;
        end else begin
            case (state_q)
                `ST_BITS: begin
                    if (scl_rise) begin
                        shift_d   = rx_byte;
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (bit_cnt_q == `LAST_BIT) begin
                            byte_done_d = 1'b1;
                            if (byte_idx_q == 4'h0) begin
                                matched_d = (rx_byte == `SLAVE_ADDR);
                                ack_ok_d  = (rx_byte == `SLAVE_ADDR);
                            end else begin
                                // Command and count bytes are acknowledged but not kept
                                ack_ok_d = matched_q && (byte_idx_q < `XFER_BYTES);
                                commit_c = matched_q && in_data;
                            end
                        end
                    end else if (scl_fall && byte_done_q && ack_ok_q) begin
                        byte_done_d = 1'b0;
                        ack_drive_d = 1'b1;
                        state_d     = `ST_ACK;
                    end else if (scl_fall && byte_done_q) begin
                        // Foreign address or past the eleventh byte: ignore until next start
                        byte_done_d = 1'b0;
                        state_d     = `ST_SKIP;
                    end
                end
                `ST_ACK: begin
                    if (scl_fall) begin
                        ack_drive_d = 1'b0;
                        ack_ok_d    = 1'b0;
                        byte_idx_d  = byte_idx_q + 4'h1;
                        state_d     = `ST_BITS;
                    end
                end
                default: begin
                    // Idle or another slave's transfer: wait for the next start
                    ack_drive_d = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q     <= `ST_IDLE;
            byte_idx_q  <= 4'h0;
            bit_cnt_q   <= 3'h0;
            shift_q     <= 8'h00;
            matched_q   <= 1'b0;
            ack_ok_q    <= 1'b0;
            ack_drive_q <= 1'b0;
            byte_done_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            byte_idx_q  <= byte_idx_d;
            bit_cnt_q   <= bit_cnt_d;
            shift_q     <= shift_d;
            matched_q   <= matched_d;
            ack_ok_q    <= ack_ok_d;
            ack_drive_q <= ack_drive_d;
            byte_done_q <= byte_done_d;
        end
    end

    // Data line is only ever pulled low for acknowledge; nothing is read back
    assign config_serial_data_out  = 1'b0;
    assign config_serial_data_oe_n = ~ack_drive_q;

    // ------------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------------
    reg [7:0] cfg_q [0:7];
    integer   k;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (k = 0; k < 8; k = k + 1) begin
                cfg_q[k] <= byte_default(k[2:0]);
            end
        end else if (commit_c) begin
            cfg_q[data_pos[2:0]] <= rx_byte & byte_mask(data_pos[2:0]);
        end
    end

    wire [7:0] freq_byte = cfg_q[`BYTE_FREQ];
    wire [7:0] cpu_byte  = cfg_q[`BYTE_CPU];
    wire [7:0] pci_byte  = cfg_q[`BYTE_PCI];
    wire [7:0] aux_byte  = cfg_q[`BYTE_AUX];
    wire [7:0] ref_byte  = cfg_q[`BYTE_REF];

    // ------------------------------------------------------------------
    // Frequency source and mode
    // ------------------------------------------------------------------
    reg [3:0] freq_sel_q;
    reg       freq_upd_q;
    wire      sw_select = freq_byte[`FREQ_SRC_BIT];
    wire [3:0] freq_sel_d = sw_select ? freq_byte[`FREQ_SEL_HI:`FREQ_SEL_LO] : strap_s;
    wire [1:0] mode      = freq_byte[`MODE_HI:`MODE_LO];

    // The synthesiser slews towards a new code; a single pulse marks the request
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            freq_sel_q <= 4'h0;
            freq_upd_q <= 1'b0;
        end else begin
            freq_sel_q <= freq_sel_d;
            freq_upd_q <= (freq_sel_d != freq_sel_q);
        end
    end

    reg spread_q;
    reg hiz_q;

    // Reserved mode 01 falls back to normal unmodulated output
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            spread_q <= 1'b0;
            hiz_q    <= 1'b0;
        end else begin
            spread_q <= (mode == `MODE_SPREAD);
            hiz_q    <= (mode == `MODE_HIZ);
        end
    end

    assign freq_select_active = freq_sel_q;
    assign freq_from_software = sw_select;
    assign spread_enable      = spread_q;
    assign freq_update        = freq_upd_q;
    assign clocks_oe_n        = hiz_q;

    // ------------------------------------------------------------------
    // Output gating
    // ------------------------------------------------------------------
    // Enables change on clk_sys, unrelated to the source clocks, so one short
    // pulse may appear when an output is switched; a cleared enable holds low.
    assign proc_clock_out_free      = proc_clk_src & cpu_byte[0];
    assign proc_clock_out_one       = proc_clk_src & cpu_byte[1];
    assign proc_clock_out_two       = proc_clk_src & cpu_byte[2];
    assign proc_clock_out_three     = proc_clk_src & cpu_byte[3];
    assign bus_clock_out_free       = bus_clk_src & pci_byte[`PCI_FREE_BIT];
    assign bus_clock_out_one        = bus_clk_src & pci_byte[0];
    assign bus_clock_out_two        = bus_clk_src & pci_byte[1];
    assign bus_clock_out_three      = bus_clk_src & pci_byte[2];
    assign bus_clock_out_four       = bus_clk_src & pci_byte[3];
    assign bus_clock_out_five       = bus_clk_src & pci_byte[4];
    assign usb_reference_clock_out  = usb_clk_src & aux_byte[`USB_BIT];
    assign superio_clock_out        = superio_clk_src & aux_byte[`SIO_BIT];
    assign memory_buffer_free       = mem_clk_src & aux_byte[`MEM_FREE_BIT];
    assign memory_buffer_group_low  = {4{mem_clk_src & aux_byte[`MEM_LOW_BIT]}};
    assign memory_buffer_group_mid  = {4{mem_clk_src & aux_byte[`MEM_MID_BIT]}};
    assign memory_buffer_group_high = {4{mem_clk_src & aux_byte[`MEM_HIGH_BIT]}};
    assign crystal_copy_out_zero    = crystal_clk_src & ref_byte[0];
    assign crystal_copy_out_one     = crystal_clk_src & ref_byte[1];

endmodule // clock_gen_serial_config

// ---- common/clock_gen_serial_config_defines.vh ----
// Constants for the serial configuration port of the clock generator.
// Assumes inclusion by bare name from design files on the 250 MHz clk_sys.
//
// Notes on behaviour
// - Registers load defaults at reset; writes optional
// - Port only receives; no read-back path
// - Eleven bytes: address, command, count, data0-7
// - Only address 11010010 updates any register
// - Command and count bytes sent, contents ignored
// - Bits arrive most significant first
// - Disabled clock outputs driven low, not floated
// - Frequency changes applied smoothly, system keeps running
// - Byte0 bit3 picks strap or software select
// - Software select bits choose CPU/SDRAM/PCI frequency
// - Byte0 bits1-0: 00 normal, 10 spread
// - Byte1 bits3-0 enable CPU outputs, default on
// - Byte2 bit6, bits4-0 enable PCI outputs
// - Byte3 bits5,4,3 enable 48, 24, SDRAM_F
// - Byte3 bits2-0 enable SDRAM groups of four
// - Byte5 bits1-0 enable reference outputs
// - Mode 11 three-states CPU, PCI, REF, 48, 24
// - Software codes apply only when bit3 set
`ifndef CLOCK_GEN_SERIAL_CONFIG_DEFINES_VH
`define CLOCK_GEN_SERIAL_CONFIG_DEFINES_VH

// ------------------------------------------------------------------
// Transfer framing
// ------------------------------------------------------------------
`define SLAVE_ADDR        8'hd2
`define XFER_BYTES        4'hb
`define FIRST_DATA_IDX    4'h3
`define LAST_BIT          3'h7

// ------------------------------------------------------------------
// Byte positions inside the data block
// ------------------------------------------------------------------
`define BYTE_FREQ         3'h0
`define BYTE_CPU          3'h1
`define BYTE_PCI          3'h2
`define BYTE_AUX          3'h3
`define BYTE_RSVD4        3'h4
`define BYTE_REF          3'h5
`define BYTE_RSVD6        3'h6
`define BYTE_RSVD7        3'h7

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define FREQ_SEL_HI       7
`define FREQ_SEL_LO       4
`define FREQ_SRC_BIT      3
`define MODE_HI           1
`define MODE_LO           0
`define PCI_FREE_BIT      6
`define USB_BIT           5
`define SIO_BIT           4
`define MEM_FREE_BIT      3
`define MEM_HIGH_BIT      2
`define MEM_MID_BIT       1
`define MEM_LOW_BIT       0
`define MODE_SPREAD       2'h2
`define MODE_HIZ          2'h3

// ------------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------------
`define DFLT_FREQ         8'h00
`define DFLT_CPU          8'h0f
`define DFLT_PCI          8'h5f
`define DFLT_AUX          8'h3f
`define DFLT_REF          8'h03
`define DFLT_RSVD         8'h00
`define MASK_FREQ         8'hfb
`define MASK_CPU          8'h0f
`define MASK_PCI          8'h5f
`define MASK_AUX          8'h3f
`define MASK_REF          8'h03
`define MASK_RSVD         8'h00

// ------------------------------------------------------------------
// Receiver states
// ------------------------------------------------------------------
`define ST_IDLE           2'h0
`define ST_BITS           2'h1
`define ST_ACK            2'h2
`define ST_SKIP           2'h3

`endif

// ---- verilog/serial_line_sampler.v ----
// Two-stage synchroniser for the serial pins and the strap inputs.
// Assumes all inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module serial_line_sampler (
    input  wire       clk_sys,   // System clock
    input  wire       rstn,      // Async reset, active low
    input  wire [5:0] async_in,  // Raw pin levels
    output wire [5:0] sync_out   // Synchronised levels
);

    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    reg [5:0] meta_q;
    reg [5:0] sync_q;

    // Both stages reset high so the bus looks idle out of reset
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 6'h3f;
            sync_q <= 6'h3f;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // serial_line_sampler

// ---- bench/clock_gen_serial_config_properties.sv ----
// Concurrent checks on the serial configuration port and output gating.
// Bound to the design top by the bench; reads top-level ports only.
`timescale 1ns/1ps
module clock_gen_serial_config_properties (
    input wire       clk_sys,                  // Clock
    input wire       rstn,                     // Reset
    input wire       config_serial_clock_pin,  // Serial clock
    input wire       config_serial_data_out,   // Drive value
    input wire       config_serial_data_oe_n,  // Drive, low on
    input wire [3:0] strap_freq_select_inputs, // Strap code
    input wire       proc_clk_src,             // CPU source
    input wire       bus_clk_src,              // PCI source
    input wire       mem_clk_src,              // SDRAM source
    input wire       crystal_clk_src,          // Crystal
    input wire [3:0] freq_select_active,       // Code
    input wire       freq_from_software,       // Soft select
    input wire       spread_enable,            // Spread
    input wire       freq_update,              // Code pulse
    input wire       clocks_oe_n,              // Three-state
    input wire       proc_clock_out_one,       // CPU 1
    input wire       bus_clock_out_five,       // PCI 5
    input wire [3:0] memory_buffer_group_high, // SDRAM 8-11
    input wire       crystal_copy_out_one      // Ref 1
);
    // ---------------------------------------
    // Settle counter
    // ---------------------------------------
    // Code changes just after reset come from the strap sync, not a write
    reg [3:0] up_q;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            up_q <= 4'h0;
        else if (up_q != 4'hf)
            up_q <= up_q + 4'h1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ---------------------------------------
    // Checks
    // ---------------------------------------
    reset_defaults_a : assert property (
        $rose(rstn) |-> !spread_enable && !clocks_oe_n && !freq_from_software) else $error("bad reset state");
    drive_low_only_a : assert property (
        !config_serial_data_oe_n |-> !config_serial_data_out) else $error("data driven high");
    drive_clk_low_a : assert property (
        $fell(config_serial_data_oe_n) |-> !config_serial_clock_pin) else $error("drive with clock high");
    mode_exclusive_a : assert property (
        !(spread_enable && clocks_oe_n)) else $error("spread and three-state");
    gated_low_a : assert property (
        (!proc_clock_out_one || proc_clk_src) && (!bus_clock_out_five || bus_clk_src)
        && (!crystal_copy_out_one || crystal_clk_src)) else $error("output high, source low");
    mem_group_a : assert property (
        memory_buffer_group_high == 4'h0 || memory_buffer_group_high == {4{mem_clk_src}}) else $error("bad group");
    update_pulse_a : assert property (
        up_q == 4'hf && $changed(freq_select_active) |-> freq_update) else $error("no update pulse");
    update_cause_a : assert property (
        freq_update |-> $changed(freq_select_active)) else $error("stray update");
    strap_follow_a : assert property (
        (!freq_from_software && $stable(strap_freq_select_inputs))[*6]
        |-> freq_select_active == strap_freq_select_inputs) else $error("strap not followed");
    commit_at_clk_a : assert property (
        $changed(freq_from_software) |-> config_serial_clock_pin) else $error("commit off a clock rise");
endmodule // clock_gen_serial_config_properties

// ---- bench/serial_config_master.sv ----
// Master model of the serial configuration bus: start, bytes, stop.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module serial_config_master (
    input  wire clk_sys, // Aligns each transfer start
    output reg  scl,     // Serial clock, high when idle
    output reg  sda_rel  // High releases data, low pulls
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // Sends nb whole bytes, tb bits of the next, then a stop.
    // Ack slots are released and ignored: the port is write-only.
    task automatic xfer(input [87:0] f, input int nb, input int tb);
        int i;
        @(posedge clk_sys);
        #1 sda_rel = 1'b0;
        #24 scl = 1'b0;
        for (i = 0; i < nb * 9 + tb; i++) begin
            #12 sda_rel = (i % 9 == 8) ? 1'b1 : f[87 - 8 * (i / 9) - i % 9];
            #12 scl = 1'b1;
            #24 scl = 1'b0;
        end
        #12 sda_rel = 1'b0;
        #12 scl = 1'b1;
        #24 sda_rel = 1'b1;
        #48;
    endtask
endmodule // serial_config_master

// ---- bench/test_clock_gen_serial_config.sv ----
// Self-checking bench for the clock generator's serial configuration port.
// Assumes the master model and the property checker are compiled first.
`timescale 1ns/1ps
module test_clock_gen_serial_config;
    reg         clk_sys;     // 250 MHz clock
    reg         rstn;        // Reset, active low
    reg  [3:0]  strap;       // Strap code
    reg         src;         // Level on all sources
    wire        scl;         // Serial clock
    wire        sda_rel;     // Master release
    wire        sda_out;     // Device drive value
    wire        sda_oe_n;    // Device drive enable
    wire        sda;         // Resolved data wire
    wire [33:0] obs;         // Status and clocks
    reg  [33:0] exp_v;       // Expected outputs
    reg  [7:0]  cfg [0:7];   // Register image
    reg  [95:0] rows [0:5];  // Strap, spare, frame
    integer     errors;
    integer     tests_run;
    integer     r;
    integer     k;
    // Pull-up: a released wire reads high
    assign sda = sda_rel & (sda_oe_n | sda_out);
    serial_config_master master (.clk_sys(clk_sys), .scl(scl), .sda_rel(sda_rel));
    clock_gen_serial_config uut (
        .clk_sys(clk_sys), .rstn(rstn), .config_serial_clock_pin(scl), .config_serial_data_pin(sda),
        .config_serial_data_out(sda_out), .config_serial_data_oe_n(sda_oe_n), .strap_freq_select_inputs(strap),
        .proc_clk_src(src), .bus_clk_src(src), .mem_clk_src(src), .usb_clk_src(src), .superio_clk_src(src),
        .crystal_clk_src(src), .freq_select_active(obs[33:30]), .freq_from_software(obs[29]),
        .spread_enable(obs[28]), .freq_update(), .clocks_oe_n(obs[27]), .proc_clock_out_free(obs[26]),
        .proc_clock_out_one(obs[25]), .proc_clock_out_two(obs[24]), .proc_clock_out_three(obs[23]),
        .bus_clock_out_free(obs[22]), .bus_clock_out_one(obs[21]), .bus_clock_out_two(obs[20]),
        .bus_clock_out_three(obs[19]), .bus_clock_out_four(obs[18]), .bus_clock_out_five(obs[17]),
        .usb_reference_clock_out(obs[16]), .superio_clock_out(obs[15]), .memory_buffer_free(obs[14]),
        .memory_buffer_group_low(obs[13:10]), .memory_buffer_group_mid(obs[9:6]),
        .memory_buffer_group_high(obs[5:2]), .crystal_copy_out_zero(obs[1]), .crystal_copy_out_one(obs[0]));
    // ---------------------------------------
    // Helpers
    // ---------------------------------------
    function [33:0] expect_obs(input [3:0] st);
        expect_obs = {cfg[0][3] ? cfg[0][7:4] : st, cfg[0][3], cfg[0][1:0] == 2'h2, cfg[0][1:0] == 2'h3,
            cfg[1][0], cfg[1][1], cfg[1][2], cfg[1][3], cfg[2][6], cfg[2][0], cfg[2][1], cfg[2][2],
            cfg[2][3], cfg[2][4], cfg[3][5], cfg[3][4], cfg[3][3], {4{cfg[3][0]}}, {4{cfg[3][1]}},
            {4{cfg[3][2]}}, cfg[5][0], cfg[5][1]};
    endfunction
    task check(input string what, input [33:0] e);
        tests_run = tests_run + 1;
        if (obs !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, e, obs);
        end
    endtask
    task settle_check(input string what);
        repeat (12) @(posedge clk_sys);
        #1 check(what, expect_obs(strap));
    endtask
    task apply_reset(input integer n);
        rstn = 1'b0;
        repeat (n) @(posedge clk_sys);
        #1 rstn = 1'b1;
        for (k = 0; k < 8; k = k + 1)
            cfg[k] = 8'h00;
        cfg[1] = 8'h0f;
        cfg[2] = 8'h5f;
        cfg[3] = 8'h3f;
        cfg[5] = 8'h03;
    endtask
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ---------------------------------------
    // Clock, watchdog, sequence
    // ---------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        errors = errors + 1;
        $display("CHECK FAILED run length expected below 30000 cycles seen limit");
        report_and_stop;
    end
    initial begin
        errors = 0;
        tests_run = 0;
        rstn = 1'b0;
        strap = 4'h7;
        src = 1'b1;
        rows[0] = 96'h50d2a508_880f5f3f_00030000;
        rows[1] = 96'ha0d200ff_62054a2a_00010000;
        rows[2] = 96'h30d21108_f30a1515_00020000;
        rows[3] = 96'hc0d23c08_01000000_00000000;
        rows[4] = 96'h60d00008_880f5f3f_00030000;
        rows[5] = 96'h90d30008_b80f5f3f_00030000;
        apply_reset(20);
        settle_check("reset defaults");
        src = 1'b0;
        exp_v = expect_obs(strap);
        #1 check("gated outputs", {exp_v[33:27], 27'h0});
        src = 1'b1;
        $display("Reset and gating test done");
        for (r = 0; r < 6; r = r + 1) begin
            strap = rows[r][95:92];
            master.xfer(rows[r][87:0], 11, 0);
            if (rows[r][87:80] == 8'hd2) begin
                for (k = 0; k < 8; k = k + 1)
                    cfg[k] = rows[r][63 - 8 * k -: 8];
            end
            settle_check("frame outputs");
            $display("Frame row %0d done", r);
        end
        // Stop after five bits of the second data byte
        master.xfer(rows[0][87:0], 4, 5);
        cfg[0] = 8'h88;
        settle_check("partial frame");
        $display("Partial frame test done");
        apply_reset(5);
        settle_check("second reset");
        $display("Second reset test done");
        report_and_stop;
    end
endmodule // test_clock_gen_serial_config
bind clock_gen_serial_config clock_gen_serial_config_properties chk (.*);
